/* dv/lctmc_ctrl_model.sv */
// Line card controller model: sinks upstream first-byte words.
// Assumes the bench raises stall to stop the controller taking words.
`timescale 1ns/1ns
module lctmc_ctrl_model (
    input wire logic clk,
    input wire logic [7:0] data,
    input wire logic valid,
    input wire logic stall,
    output logic ready
);
    logic [7:0] got[$];
    initial ready = 1'b0;
    always @(posedge clk) ready <= !stall;
    always @(posedge clk) if (valid && ready) got.push_back(data);
endmodule

/* dv/lctmc_top_assertions.sv */
// Port checker for the test-mode controller.
// Assumes control fields stay put while a test runs.
`timescale 1ns/1ns
module lctmc_chk
    import lctmc_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic TEST_ENABLE_BIT,
    input wire logic [3:0] TEST_SELECT,
    input wire logic ALT_TEST_SELECT,
    input wire logic TONE_1K_ADD,
    input wire logic RING_TRIP_ENABLE,
    input wire logic METERING_TONE_SELECT_BIT,
    input wire logic [7:0] METERING_LEVEL_REG,
    input wire logic VOICE_VALID,
    input wire logic VOICE_READY,
    input wire logic [7:0] TX_B1_DATA,
    input wire logic TX_B1_VALID,
    input wire logic TX_B1_READY,
    input wire logic B_FILTER_ON,
    input wire logic Z_FILTER_ON,
    input wire logic RX_PATH_ON,
    input wire logic TX_PATH_ON,
    input wire logic RX_INPUT_ON,
    input wire logic [4:0] RX_GAIN_SHIFT,
    input wire logic IMPEDANCE_SYNTH_ON,
    input wire logic CURRENT_LIMIT_ON,
    input wire logic DC_FEED_ON,
    input wire logic [4:0] DROP_STEPS,
    input wire logic SENSE_DC_ONLY,
    input wire logic RING_MODE,
    input wire logic AUTO_RING_TRIP,
    input wire logic TONE_800_ON,
    input wire logic [7:0] TONE_LEVEL,
    input wire logic SHAPING_ON,
    input wire logic WINDOW_DET_ON,
    input wire logic MEASUREMENT_SETTLED_FLAG
);
    // ------------------------------------------------------------
    // Mode decode and properties
    // ------------------------------------------------------------
    wire logic t = TEST_ENABLE_BIT && !ALT_TEST_SELECT;
    wire logic lk = t && (TEST_SELECT == SEL_LEAK || TEST_SELECT == SEL_LKA);
    wire logic im = t && (TEST_SELECT == SEL_IMPDC || TEST_SELECT == SEL_IMPAC);
    wire logic ac = t && TEST_SELECT == SEL_IMPAC;
    wire logic rg = t && TEST_SELECT == SEL_IRING;
    wire logic pt = t && TEST_SELECT == SEL_PTTX;
    wire logic t8 = t && TEST_SELECT == SEL_TONE800;
    wire logic tc = t && TEST_SELECT == SEL_TONECAL;
    wire logic al = t && TEST_SELECT == SEL_ALB;
    default clocking @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);
    chk_test_off_idle: assert property ((!TEST_ENABLE_BIT)[*6] |->
        !WINDOW_DET_ON && !TONE_800_ON && RX_GAIN_SHIFT == 5'h0 && !MEASUREMENT_SETTLED_FLAG)
        else $error("test outputs active while disabled");
    chk_leak_paths: assert property (lk[*6] |-> !B_FILTER_ON && !Z_FILTER_ON && RX_PATH_ON)
        else $error("leakage path setup wrong");
    chk_tone_line: assert property ((t8 && $stable({TONE_1K_ADD, METERING_LEVEL_REG}))[*6]
        |-> TONE_800_ON && TONE_LEVEL == METERING_LEVEL_REG && RX_INPUT_ON == !TONE_1K_ADD)
        else $error("line tone setup wrong");
    chk_tonecal_tx: assert property (tc[*6] |-> !TX_PATH_ON)
        else $error("transmit path on in tone calibration");
    chk_loop_active: assert property (al[*6] |-> WINDOW_DET_ON && TX_PATH_ON && RX_PATH_ON)
        else $error("loopback setup wrong");
    chk_imp_setup: assert property ((im && $stable(METERING_LEVEL_REG))[*6] |->
        RX_GAIN_SHIFT == 5'(GAIN_SHIFT) && !IMPEDANCE_SYNTH_ON && !CURRENT_LIMIT_ON
        && !DC_FEED_ON && DROP_STEPS == METERING_LEVEL_REG[7:3])
        else $error("impedance setup wrong");
    chk_ac_sense: assert property (ac[*6] |-> SENSE_DC_ONLY)
        else $error("ac impedance sense wrong");
    chk_ring_paths: assert property ((rg && $stable(RING_TRIP_ENABLE))[*6] |->
        RING_MODE && !B_FILTER_ON && !Z_FILTER_ON && !RX_PATH_ON && TX_PATH_ON
        && AUTO_RING_TRIP == RING_TRIP_ENABLE)
        else $error("ring test setup wrong");
    chk_pseudo_tone: assert property ((pt && $stable(METERING_TONE_SELECT_BIT))[*6] |->
        TONE_800_ON == !METERING_TONE_SELECT_BIT && !SHAPING_ON && WINDOW_DET_ON)
        else $error("pseudo metering setup wrong");
    chk_out_hold: assert property (TX_B1_VALID && !TX_B1_READY |=>
        TX_B1_VALID && $stable(TX_B1_DATA))
        else $error("upstream byte dropped or changed");
    chk_push_answer: assert property (VOICE_VALID && VOICE_READY |=> TX_B1_VALID)
        else $error("pushed byte not offered");
endmodule
bind lctmc_top lctmc_chk chk (.*);

/* dv/lctmc_top_test.sv */
// Testbench for the test-mode controller with a controller sink model.
// Assumes lctmc_chk is bound to the design.
`timescale 1ns/1ns
module lctmc_top_test;
    import lctmc_pkg::*;
    logic SYS_CLK, RESET_N, TEST_ENABLE_BIT, ALT_TEST_SELECT, WIRE_SEL_TIP, WIRE_SEL_RING;
    logic RESULT_MODULATION_BIT, TONE_1K_ADD, BATTERY_REVERSED, RING_TRIP_ENABLE;
    logic METERING_TONE_SELECT_BIT, HOOK_IN, ENC_SAMPLE_VALID, VOICE_VALID, VOICE_READY;
    logic TX_B1_VALID, TX_B1_READY, B_FILTER_ON, Z_FILTER_ON, RX_PATH_ON, TX_PATH_ON;
    logic RX_INPUT_ON, IMPEDANCE_SYNTH_ON, CURRENT_LIMIT_ON, DC_FEED_ON, SENSE_DC_ONLY;
    logic RING_MODE, AUTO_RING_TRIP, HOOK_UPSTREAM, TONE_800_ON, TONE_1K_ON, SHAPING_ON;
    logic WINDOW_DET_ON, MEASUREMENT_SETTLED_FLAG, TONE_IN_WINDOW_FLAG, RING_AMPLITUDE_OK_FLAG;
    logic [3:0] TEST_SELECT;
    logic [4:0] RX_GAIN_SHIFT, DROP_STEPS;
    logic [1:0] LEAK_MEAS_SEL, a;
    logic [15:0] ENC_SAMPLE;
    logic [7:0] METERING_LEVEL_REG, MEAS_WORD, RING_AMP, RING_AMP_MIN, RING_AMP_MAX, VOICE_BYTE;
    logic [7:0] TX_B1_DATA, TONE_LEVEL;
    logic [3:0] codes[9] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h9, 4'ha, 4'hc, 4'hd};
    logic stall;
    int error_cnt, cmp_count;
    lctmc_top #(.SETTLE(2)) dut (.*);
    lctmc_ctrl_model ctrl (.clk(SYS_CLK), .data(TX_B1_DATA), .valid(TX_B1_VALID),
        .stall(stall), .ready(TX_B1_READY));
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic set_mode(input logic en, input logic [3:0] c);
        @(negedge SYS_CLK);
        TEST_ENABLE_BIT = en;
        TEST_SELECT = c;
        repeat (6) @(negedge SYS_CLK);
    endtask
    task automatic push(input logic [7:0] b);
        int n;
        n = 0;
        @(negedge SYS_CLK);
        VOICE_BYTE = b;
        VOICE_VALID = 1'b1;
        @(posedge SYS_CLK);
        while (VOICE_READY !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge SYS_CLK);
        end
        @(negedge SYS_CLK);
        VOICE_VALID = 1'b0;
        chk(n < 50, 1'b1);
    endtask
    task automatic drain(input int n);
        int k;
        k = 0;
        @(negedge SYS_CLK);
        VOICE_VALID = 1'b0;
        stall = 1'b0;
        while (ctrl.got.size() < n && k < 100)
        begin
            k++;
            @(negedge SYS_CLK);
        end
        chk(ctrl.got.size(), n);
    endtask
    task automatic samp(input logic [15:0] v, input int n);
        repeat (n)
        begin
            @(negedge SYS_CLK);
            ENC_SAMPLE = v;
            ENC_SAMPLE_VALID = 1'b1;
            @(negedge SYS_CLK);
            ENC_SAMPLE_VALID = 1'b0;
        end
        repeat (3) @(negedge SYS_CLK);
    endtask
    task automatic summarize;
        $display("errors=%0d compares=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    initial
    begin
        #2000000;
        error_cnt++;
        summarize();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial
    begin
        {RESET_N, TEST_ENABLE_BIT, ALT_TEST_SELECT, WIRE_SEL_TIP, WIRE_SEL_RING} = '0;
        {RESULT_MODULATION_BIT, BATTERY_REVERSED, RING_TRIP_ENABLE, HOOK_IN} = '0;
        {METERING_TONE_SELECT_BIT, ENC_SAMPLE_VALID, VOICE_VALID, VOICE_BYTE} = '0;
        {TEST_SELECT, ENC_SAMPLE, METERING_LEVEL_REG} = '0;
        TONE_1K_ADD = 1'b1;
        MEAS_WORD = 8'h5a;
        {RING_AMP, RING_AMP_MIN, RING_AMP_MAX} = {8'h40, 8'h30, 8'h50};
        stall = 1'b1;
        repeat (10) @(negedge SYS_CLK);
        RESET_N = 1'b1;
        set_mode(1'b0, SEL_LEAK);
        for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
        @(negedge SYS_CLK);
        chk(VOICE_READY, 1'b0);
        drain(8);
        for (int i = 0; i < 8; i++) chk(ctrl.got[i], 8'h10 + 8'(i));
        ctrl.got.delete();
        set_mode(1'b1, SEL_LEAK);
        push(8'h01);
        RESULT_MODULATION_BIT = 1'b1;
        push(8'h02);
        push(8'h03);
        drain(3);
        chk(ctrl.got[0], MEAS_WORD);
        chk(ctrl.got[1] ^ ctrl.got[2], 8'hff);
        chk(ctrl.got[1] == MEAS_WORD || ctrl.got[1] == ~MEAS_WORD, 1'b1);
        RESULT_MODULATION_BIT = 1'b0;
        chk(LEAK_MEAS_SEL, 2'b00);
        WIRE_SEL_TIP = 1'b1;
        repeat (4) @(negedge SYS_CLK);
        a = LEAK_MEAS_SEL;
        chk(a, 2'b01);
        {WIRE_SEL_TIP, WIRE_SEL_RING} = 2'b01;
        repeat (4) @(negedge SYS_CLK);
        chk(a !== LEAK_MEAS_SEL, 1'b1);
        chk(LEAK_MEAS_SEL, 2'b10);
        WIRE_SEL_RING = 1'b0;
        ctrl.got.delete();
        set_mode(1'b1, SEL_LKA);
        push(8'h21);
        ALT_TEST_SELECT = 1'b1;
        set_mode(1'b1, SEL_LEAK);
        push(8'h22);
        ALT_TEST_SELECT = 1'b0;
        set_mode(1'b1, SEL_TONECAL);
        push(8'h23);
        drain(3);
        chk(ctrl.got[0], MEAS_WORD);
        chk(ctrl.got[1], 8'h22);
        chk(ctrl.got[2] == TONE_MAX_CODE || ctrl.got[2] == ~TONE_MAX_CODE, 1'b1);
        METERING_LEVEL_REG = 8'hb8;
        foreach (codes[i])
        begin
            set_mode(1'b1, codes[i]);
            chk(WINDOW_DET_ON, codes[i] inside {SEL_ALB, SEL_IRING, SEL_PTTX});
            chk(RX_GAIN_SHIFT, codes[i] inside {SEL_IMPDC, SEL_IMPAC} ? 5'h4 : 5'h0);
            if (codes[i] inside {SEL_IMPDC, SEL_IMPAC})
                chk(TONE_1K_ON, 1'b1);
        end
        set_mode(1'b0, SEL_ALB);
        set_mode(1'b1, SEL_ALB);
        samp(WIN_CENTRE, 4);
        chk(MEASUREMENT_SETTLED_FLAG, 1'b1);
        chk(TONE_IN_WINDOW_FLAG, 1'b1);
        samp(16'h4800, 2);
        chk(TONE_IN_WINDOW_FLAG, 1'b0);
        BATTERY_REVERSED = 1'b1;
        set_mode(1'b0, SEL_ALB);
        set_mode(1'b1, SEL_ALB);
        samp(16'hb800, 4);
        chk(TONE_IN_WINDOW_FLAG, 1'b1);
        HOOK_IN = 1'b1;
        set_mode(1'b1, SEL_IRING);
        samp(16'h0100, 4);
        chk(RING_AMPLITUDE_OK_FLAG, 1'b1);
        chk(HOOK_UPSTREAM, 1'b1);
        RING_AMP = 8'h60;
        samp(16'h0100, 1);
        chk(RING_AMPLITUDE_OK_FLAG, 1'b0);
        set_mode(1'b0, SEL_IRING);
        chk(MEASUREMENT_SETTLED_FLAG, 1'b0);
        summarize();
    end
endmodule

/* hdl/lctmc_fifo.sv */
// Word FIFO with valid and ready on both sides.
// Assumes one clock and an active-low asynchronous reset already synchronised.
`timescale 1ns/1ns
module lctmc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_comb
    begin
        wr_d = push ? ((wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = pop ? ((rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clk)
    begin
        if (push)
            mem_q[wr_q] <= in_data;
    end
endmodule

/* hdl/lctmc_top.sv */
// Line and circuit test-mode controller: mode decode, path control,
// test tones, window detector, and upstream first-byte selection.
// Assumes control fields are static ports from the codec register file.
`timescale 1ns/1ns
module lctmc_top
    import lctmc_pkg::*;
#(
    parameter int SETTLE = lctmc_pkg::SETTLE_SAMPLES
) (
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic TEST_ENABLE_BIT,
    input wire logic [3:0] TEST_SELECT,
    input wire logic ALT_TEST_SELECT,
    input wire logic WIRE_SEL_TIP,
    input wire logic WIRE_SEL_RING,
    input wire logic RESULT_MODULATION_BIT,
    input wire logic TONE_1K_ADD,
    input wire logic BATTERY_REVERSED,
    input wire logic RING_TRIP_ENABLE,
    input wire logic METERING_TONE_SELECT_BIT,
    input wire logic [7:0] METERING_LEVEL_REG,
    input wire logic HOOK_IN,
    input wire logic [15:0] ENC_SAMPLE,
    input wire logic ENC_SAMPLE_VALID,
    input wire logic [7:0] MEAS_WORD,
    input wire logic [7:0] RING_AMP,
    input wire logic [7:0] RING_AMP_MIN,
    input wire logic [7:0] RING_AMP_MAX,
    input wire logic [7:0] VOICE_BYTE,
    input wire logic VOICE_VALID,
    output logic VOICE_READY,
    output logic [7:0] TX_B1_DATA,
    output logic TX_B1_VALID,
    input wire logic TX_B1_READY,
    output logic B_FILTER_ON,
    output logic Z_FILTER_ON,
    output logic RX_PATH_ON,
    output logic TX_PATH_ON,
    output logic RX_INPUT_ON,
    output logic [4:0] RX_GAIN_SHIFT,
    output logic IMPEDANCE_SYNTH_ON,
    output logic CURRENT_LIMIT_ON,
    output logic DC_FEED_ON,
    output logic [4:0] DROP_STEPS,
    output logic SENSE_DC_ONLY,
    output logic [1:0] LEAK_MEAS_SEL,
    output logic RING_MODE,
    output logic AUTO_RING_TRIP,
    output logic HOOK_UPSTREAM,
    output logic TONE_800_ON,
    output logic TONE_1K_ON,
    output logic [7:0] TONE_LEVEL,
    output logic SHAPING_ON,
    output logic WINDOW_DET_ON,
    output logic MEASUREMENT_SETTLED_FLAG,
    output logic TONE_IN_WINDOW_FLAG,
    output logic RING_AMPLITUDE_OK_FLAG
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_a_q, rst_n_q;

    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rst_a_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_a_q <= 1'b1;
            rst_n_q <= rst_a_q;
        end
    end

    // ------------------------------------------------------------
    // Hook pin synchroniser
    // ------------------------------------------------------------
    logic [2:0] hook_sync_q, hook_sync_d;
    logic hook_q, hook_d;

    always_comb
    begin
        hook_sync_d = {hook_sync_q[1:0], HOOK_IN};
        hook_d = (hook_sync_q[2] == hook_sync_q[1]) ? hook_sync_q[2] : hook_q;
    end

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    lctmc_mode_t mode_q, mode_d;

    always_comb
    begin
        mode_d = ST_NORMAL;
        if (TEST_ENABLE_BIT && !ALT_TEST_SELECT)
        begin
            case (TEST_SELECT)
                SEL_LEAK: mode_d = ST_LEAK;
                SEL_LKA: mode_d = ST_LKA;
                SEL_TONE800: mode_d = ST_TONE800;
                SEL_TONECAL: mode_d = ST_TONECAL;
                SEL_ALB: mode_d = ST_ALB;
                SEL_IMPDC: mode_d = ST_IMPDC;
                SEL_IMPAC: mode_d = ST_IMPAC;
                SEL_IRING: mode_d = ST_IRING;
                SEL_PTTX: mode_d = ST_PTTX;
                default: mode_d = ST_NORMAL;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Path and line control
    // ------------------------------------------------------------
    typedef struct packed {
        logic b_on, z_on, rx_on, tx_on, rx_in, synth, ilim, feed, dc_only;
        logic ring, trip, t800, t1k, shape, win;
        logic [4:0] gain, drop;
        logic [1:0] leak;
        logic [7:0] lvl;
    } lctmc_ctl_t;

    lctmc_ctl_t ctl_q, ctl_d;
    logic leak_mode, imp_mode;

    assign leak_mode = (mode_q == ST_LEAK) || (mode_q == ST_LKA);
    assign imp_mode = (mode_q == ST_IMPDC) || (mode_q == ST_IMPAC);

    always_comb
    begin
        ctl_d = '0;
        ctl_d.b_on = 1'b1;
        ctl_d.z_on = 1'b1;
        ctl_d.rx_on = 1'b1;
        ctl_d.tx_on = 1'b1;
        ctl_d.rx_in = 1'b1;
        ctl_d.synth = 1'b1;
        ctl_d.ilim = 1'b1;
        ctl_d.feed = 1'b1;
        ctl_d.trip = 1'b1;
        ctl_d.shape = 1'b1;
        case (mode_q)
            ST_LEAK, ST_LKA:
            begin
                ctl_d.b_on = 1'b0;
                ctl_d.z_on = 1'b0;
                ctl_d.ilim = 1'b0;
                ctl_d.leak = {WIRE_SEL_RING, WIRE_SEL_TIP};
                ctl_d.dc_only = (mode_q == ST_LKA);
            end
            ST_TONE800:
            begin
                ctl_d.t800 = 1'b1;
                ctl_d.lvl = METERING_LEVEL_REG;
                ctl_d.t1k = TONE_1K_ADD;
                ctl_d.rx_in = !TONE_1K_ADD;
            end
            ST_TONECAL:
            begin
                ctl_d.tx_on = 1'b0;
                ctl_d.t1k = TONE_1K_ADD;
            end
            ST_ALB:
            begin
                ctl_d.win = 1'b1;
                ctl_d.t1k = TONE_1K_ADD;
            end
            ST_IMPDC, ST_IMPAC:
            begin
                ctl_d.gain = 5'(GAIN_SHIFT);
                ctl_d.t1k = TONE_1K_ADD;
                ctl_d.z_on = 1'b0;
                ctl_d.synth = 1'b0;
                ctl_d.ilim = 1'b0;
                ctl_d.feed = 1'b0;
                ctl_d.drop = METERING_LEVEL_REG[DROP_MSB:DROP_LSB];
                ctl_d.dc_only = (mode_q == ST_IMPAC);
            end
            ST_IRING:
            begin
                ctl_d.ring = 1'b1;
                ctl_d.trip = RING_TRIP_ENABLE;
                ctl_d.b_on = 1'b0;
                ctl_d.z_on = 1'b0;
                ctl_d.rx_on = 1'b0;
                ctl_d.rx_in = 1'b0;
                ctl_d.win = 1'b1;
            end
            ST_PTTX:
            begin
                ctl_d.t800 = !METERING_TONE_SELECT_BIT;
                ctl_d.lvl = METERING_LEVEL_REG;
                ctl_d.shape = 1'b0;
                ctl_d.win = 1'b1;
                ctl_d.t1k = TONE_1K_ADD;
            end
            default:
            begin
                ctl_d.trip = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Window detector and settle counter
    // ------------------------------------------------------------
    localparam int SW = $clog2(SETTLE + 1);
    logic [15:0] peak;
    logic [15:0] half;
    logic in_win;
    logic [SW-1:0] settle_q, settle_d;
    logic settled_q, settled_d, tone_in_window_flag_q, tone_in_window_flag_d, ring_amplitude_ok_flag_q, ring_amplitude_ok_flag_d;
    lctmc_mode_t prev_mode_q;

    always_comb
    begin
        // Negative peak when battery reversed, positive otherwise
        peak = BATTERY_REVERSED ? (ENC_SAMPLE[15] ? (16'h0000 - ENC_SAMPLE) : 16'h0000)
                                : (ENC_SAMPLE[15] ? 16'h0000 : ENC_SAMPLE);
        half = BATTERY_REVERSED ? WIN_HALF_WIDE : WIN_HALF_NARROW;
        in_win = (peak >= WIN_CENTRE - half) && (peak <= WIN_CENTRE + half);
        settle_d = settle_q;
        settled_d = settled_q;
        tone_in_window_flag_d = tone_in_window_flag_q;
        ring_amplitude_ok_flag_d = ring_amplitude_ok_flag_q;
        if (mode_q != prev_mode_q || !ctl_q.win)
        begin
            settle_d = '0;
            settled_d = 1'b0;
            tone_in_window_flag_d = 1'b0;
            ring_amplitude_ok_flag_d = 1'b0;
        end
        else if (ENC_SAMPLE_VALID)
        begin
            if (settle_q != SW'(SETTLE))
                settle_d = settle_q + 1'b1;
            else
            begin
                settled_d = 1'b1;
                tone_in_window_flag_d = in_win;
                ring_amplitude_ok_flag_d = (mode_q == ST_IRING) && (RING_AMP >= RING_AMP_MIN)
                          && (RING_AMP <= RING_AMP_MAX);
            end
        end
    end

    // ------------------------------------------------------------
    // First transmit byte source
    // ------------------------------------------------------------
    localparam int PW = $clog2(TONE_STEPS);
    logic [7:0] tone_sample;
    logic [7:0] b1_d;
    logic b1_valid;
    // Byte phase: bit 0 alternates, top bit gives a 1 kHz square
    logic [PW-1:0] mod_ph_q, mod_ph_d;
    logic f_ready;

    assign tone_sample = TONE_MAX_CODE;
    always_comb
    begin
        mod_ph_d = VOICE_VALID && f_ready ? mod_ph_q + 1'b1 : mod_ph_q;
        b1_d = VOICE_BYTE;
        if (mode_q == ST_TONECAL)
            b1_d = mod_ph_q[PW-1] ? ~tone_sample : tone_sample;
        else if (leak_mode || imp_mode || mode_q == ST_IRING || mode_q == ST_PTTX
                 || mode_q == ST_ALB)
        begin
            b1_d = MEAS_WORD;
            if (RESULT_MODULATION_BIT && mod_ph_q[0])
                b1_d = ~MEAS_WORD;
        end
    end

    assign b1_valid = VOICE_VALID;
    assign VOICE_READY = f_ready;

    lctmc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(SYS_CLK),
        .rst_n(rst_n_q),
        .in_data(b1_d),
        .in_valid(b1_valid),
        .in_ready(f_ready),
        .out_data(TX_B1_DATA),
        .out_valid(TX_B1_VALID),
        .out_ready(TX_B1_READY)
    );

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            hook_sync_q <= '0;
            hook_q <= 1'b0;
            mode_q <= ST_NORMAL;
            prev_mode_q <= ST_NORMAL;
            ctl_q <= '0;
            settle_q <= '0;
            settled_q <= 1'b0;
            tone_in_window_flag_q <= 1'b0;
            ring_amplitude_ok_flag_q <= 1'b0;
            mod_ph_q <= '0;
        end
        else
        begin
            hook_sync_q <= hook_sync_d;
            hook_q <= hook_d;
            mode_q <= mode_d;
            prev_mode_q <= mode_q;
            ctl_q <= ctl_d;
            settle_q <= settle_d;
            settled_q <= settled_d;
            tone_in_window_flag_q <= tone_in_window_flag_d;
            ring_amplitude_ok_flag_q <= ring_amplitude_ok_flag_d;
            mod_ph_q <= mod_ph_d;
        end
    end

    assign B_FILTER_ON = ctl_q.b_on;
    assign Z_FILTER_ON = ctl_q.z_on;
    assign RX_PATH_ON = ctl_q.rx_on;
    assign TX_PATH_ON = ctl_q.tx_on;
    assign RX_INPUT_ON = ctl_q.rx_in;
    assign RX_GAIN_SHIFT = ctl_q.gain;
    assign IMPEDANCE_SYNTH_ON = ctl_q.synth;
    assign CURRENT_LIMIT_ON = ctl_q.ilim;
    assign DC_FEED_ON = ctl_q.feed;
    assign DROP_STEPS = ctl_q.drop;
    assign SENSE_DC_ONLY = ctl_q.dc_only;
    assign LEAK_MEAS_SEL = ctl_q.leak;
    assign RING_MODE = ctl_q.ring;
    assign AUTO_RING_TRIP = ctl_q.trip;
    assign HOOK_UPSTREAM = hook_q;
    assign TONE_800_ON = ctl_q.t800;
    assign TONE_1K_ON = ctl_q.t1k;
    assign TONE_LEVEL = ctl_q.lvl;
    assign SHAPING_ON = ctl_q.shape;
    assign WINDOW_DET_ON = ctl_q.win;
    assign MEASUREMENT_SETTLED_FLAG = settled_q;
    assign TONE_IN_WINDOW_FLAG = tone_in_window_flag_q;
    assign RING_AMPLITUDE_OK_FLAG = ring_amplitude_ok_flag_q;
endmodule

/* shared/lctmc_pkg.sv */
// Constants for the line and circuit test-mode controller.
// Assumes control register fields arrive as plain ports from the host codec.
package lctmc_pkg;

    // ------------------------------------------------------------
    // Test-select codes
    // ------------------------------------------------------------
    localparam logic [3:0] SEL_LEAK = 4'h1;
    localparam logic [3:0] SEL_LKA = 4'h2;
    localparam logic [3:0] SEL_TONE800 = 4'h4;
    localparam logic [3:0] SEL_TONECAL = 4'h5;
    localparam logic [3:0] SEL_ALB = 4'h7;
    localparam logic [3:0] SEL_IMPDC = 4'h9;
    localparam logic [3:0] SEL_IMPAC = 4'ha;
    localparam logic [3:0] SEL_IRING = 4'hc;
    localparam logic [3:0] SEL_PTTX = 4'hd;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int DROP_MSB = 7;
    localparam int DROP_LSB = 3;
    localparam int GAIN_SHIFT = 4;
    localparam int TIM_BIT = 5;
    localparam logic [15:0] FULL_SCALE = 16'h7fff;
    localparam logic [15:0] WIN_CENTRE = 16'h4000;
    // Half widths of the window about -6 dB: about 1 dB and 3 dB
    localparam logic [15:0] WIN_HALF_NARROW = 16'h0764;
    localparam logic [15:0] WIN_HALF_WIDE = 16'h15ee;
    localparam logic [7:0] TONE_MAX_CODE = 8'h7f;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20000000;
    localparam int SAMPLE_HZ = 8000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int TONE_HZ = 1000;
    localparam int TONE_STEPS = SAMPLE_HZ / TONE_HZ;
    localparam int SETTLE_SAMPLES = 16;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [3:0] {
        ST_NORMAL = 4'b0000,
        ST_LEAK = 4'b0001,
        ST_LKA = 4'b0011,
        ST_TONE800 = 4'b0010,
        ST_TONECAL = 4'b0110,
        ST_ALB = 4'b0111,
        ST_IMPDC = 4'b0101,
        ST_IMPAC = 4'b0100,
        ST_IRING = 4'b1100,
        ST_PTTX = 4'b1101
    } lctmc_mode_t;

endpackage
